// ===== core/bstap_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bstap_map.svh"
module bstap_top #(
  // Identity fields; the values are arbitrary.
  parameter logic [3:0] ID_VERSION = 4'h1,
  parameter logic [15:0] ID_PART = 16'h1234,
  parameter logic [10:0] ID_MAKER = 11'h0aa
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Test access port
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Pads
  input wire logic [`BSTAP_NRX-1:0] pad_in,
  output bstap_pkg::bstap_drive_t pad_drv,
  // Core
  input wire bstap_pkg::bstap_drive_t core_drv,
  output logic [`BSTAP_NRX-1:0] core_in
);

  // ****************************************************************
  // Instruction decoding.
  // ****************************************************************
  function automatic logic sel_bsr(input logic [`BSTAP_IR_W-1:0] op);
    sel_bsr = (op == `BSTAP_OP_EXTEST) || (op == `BSTAP_OP_SAMPLE) ||
              (op == `BSTAP_OP_INTEST);
  endfunction

  function automatic logic sel_id(input logic [`BSTAP_IR_W-1:0] op);
    sel_id = (op == `BSTAP_OP_IDCODE);
  endfunction

  // ****************************************************************
  // Controller.
  // ****************************************************************
  bstap_pkg::bstap_state_t state;

  bstap_ctrl u_ctrl (
    .tck(tck),
    .trst_n(trst_n),
    .tms(tms),
    .state(state)
  );

  logic cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir, in_tlr;

  assign cap_dr = (state == bstap_pkg::ST_CAP_DR);
  assign sh_dr = (state == bstap_pkg::ST_SH_DR);
  assign upd_dr = (state == bstap_pkg::ST_UPD_DR);
  assign cap_ir = (state == bstap_pkg::ST_CAP_IR);
  assign sh_ir = (state == bstap_pkg::ST_SH_IR);
  assign upd_ir = (state == bstap_pkg::ST_UPD_IR);
  assign in_tlr = (state == bstap_pkg::ST_TLR);

  // ****************************************************************
  // Synchronisers into the test clock domain.
  // ****************************************************************
  logic [`BSTAP_NRX-1:0] pin_t1_q, pin_t2_q;
  bstap_pkg::bstap_drive_t core_t1_q, core_t2_q;

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      pin_t1_q <= '0;
      pin_t2_q <= '0;
      core_t1_q <= '0;
      core_t2_q <= '0;
    end else begin
      pin_t1_q <= pad_in;
      pin_t2_q <= pin_t1_q;
      core_t1_q <= core_drv;
      core_t2_q <= core_t1_q;
    end
  end

  // ****************************************************************
  // Boundary cell mapping.
  // ****************************************************************
  logic [`BSTAP_NCELLS-1:0] cap_vec, upd_vec;
  logic bsr_so;

  // Two-way pins: capture, data, enable. Capture cells see the pads,
  // data and enable cells see what the core drives.
  genvar g;
  generate
    for (g = 0; g < `BSTAP_NIO; g++) begin : g_io
      assign cap_vec[3*g] = pin_t2_q[g];
      assign cap_vec[3*g+1] = core_t2_q.dat[g];
      assign cap_vec[3*g+2] = core_t2_q.oe[g];
    end
    for (g = 0; g < `BSTAP_NOUT; g++) begin : g_out
      assign cap_vec[`BSTAP_OUT_CELL+2*g] = core_t2_q.dat[`BSTAP_NIO+g];
      assign cap_vec[`BSTAP_OUT_CELL+2*g+1] = core_t2_q.oe[`BSTAP_NIO+g];
    end
    for (g = 0; g < `BSTAP_NIN; g++) begin : g_in
      assign cap_vec[`BSTAP_IN_CELL+g] = pin_t2_q[`BSTAP_NIO+g];
    end
  endgenerate

  logic [`BSTAP_IR_W-1:0] ir_q, ir_d, ir_sr_q, ir_sr_d;
  logic bsr_cap, bsr_sh, bsr_upd;

  // Capture and update happen only in the matching states.
  assign bsr_cap = cap_dr && sel_bsr(ir_q);
  assign bsr_sh = sh_dr && sel_bsr(ir_q);
  assign bsr_upd = upd_dr && sel_bsr(ir_q);

  bstap_bsr u_bsr (
    .tck(tck),
    .trst_n(trst_n),
    .capture(bsr_cap),
    .shift(bsr_sh),
    .update(bsr_upd),
    .tdi(tdi),
    .so(bsr_so),
    .cap_vec(cap_vec),
    .upd_vec(upd_vec)
  );

  // ****************************************************************
  // Instruction, identity and bypass registers.
  // ****************************************************************
  logic [`BSTAP_ID_W-1:0] id_q, id_d;
  logic byp_q, byp_d, tgl_q, tgl_d;
  bstap_pkg::bstap_mode_t mode_q, mode_d;

  always_comb begin
    ir_d = ir_q;
    ir_sr_d = ir_sr_q;
    id_d = id_q;
    byp_d = byp_q;
    tgl_d = tgl_q ^ bsr_upd;
    if (in_tlr) begin
      ir_d = `BSTAP_OP_IDCODE;
    end else if (upd_ir) begin
      ir_d = ir_sr_q;
    end
    if (cap_ir) begin
      ir_sr_d = `BSTAP_IR_CAPT;
    end else if (sh_ir) begin
      ir_sr_d = {tdi, ir_sr_q[`BSTAP_IR_W-1:1]};
    end
    if (cap_dr) begin
      id_d = {ID_VERSION, ID_PART, ID_MAKER, `BSTAP_ID_LSB};
      byp_d = `BSTAP_BYP_CAPT;
    end else if (sh_dr) begin
      id_d = {tdi, id_q[`BSTAP_ID_W-1:1]};
      byp_d = tdi;
    end
    mode_d.pad_from_bsr = (ir_q == `BSTAP_OP_EXTEST) ||
                          (ir_q == `BSTAP_OP_INTEST) ||
                          (ir_q == `BSTAP_OP_CLAMP);
    mode_d.core_from_bsr = (ir_q == `BSTAP_OP_INTEST);
    mode_d.hiz = (ir_q == `BSTAP_OP_HIGHZ);
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_q <= `BSTAP_OP_IDCODE;
      ir_sr_q <= `BSTAP_IR_CAPT;
      id_q <= '0;
      byp_q <= `BSTAP_BYP_CAPT;
      tgl_q <= 1'b0;
      mode_q <= '0;
    end else begin
      ir_q <= ir_d;
      ir_sr_q <= ir_sr_d;
      id_q <= id_d;
      byp_q <= byp_d;
      tgl_q <= tgl_d;
      mode_q <= mode_d;
    end
  end

  // ****************************************************************
  // Serial output on the falling test clock edge.
  // ****************************************************************
  logic tdo_q, tdo_d, oe_q, oe_d;

  always_comb begin
    tdo_d = 1'b0;
    oe_d = 1'b0;
    if (sh_ir) begin
      tdo_d = ir_sr_q[0];
      oe_d = 1'b1;
    end else if (sh_dr) begin
      oe_d = 1'b1;
      if (sel_bsr(ir_q)) begin
        tdo_d = bsr_so;
      end else if (sel_id(ir_q)) begin
        tdo_d = id_q[0];
      end else begin
        tdo_d = byp_q;
      end
    end
  end

  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      tdo_q <= tdo_d;
      oe_q <= oe_d;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = oe_q;

  // ****************************************************************
  // Crossing into the system clock domain.
  // ****************************************************************
  // The update vector is held stable for at least four test clocks after
  // each toggle, so it is copied once the synchronised toggle moves.
  // The mode word is taken only once two samples agree, so a word caught
  // half changed never reaches the pads.
  bstap_pkg::bstap_mode_t mode_s1_q, mode_s2_q, mode_s3_q;
  bstap_pkg::bstap_mode_t mode_use_q, mode_use_d;
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
  logic [`BSTAP_NCELLS-1:0] upd_sys_q, upd_sys_d;
  logic [`BSTAP_NRX-1:0] pin_s1_q, pin_s2_q;

  always_comb begin
    upd_sys_d = upd_sys_q;
    mode_use_d = mode_use_q;
    if (tgl_s2_q ^ tgl_s3_q) begin
      upd_sys_d = upd_vec;
    end
    if (mode_s2_q == mode_s3_q) begin
      mode_use_d = mode_s2_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_s1_q <= '0;
      mode_s2_q <= '0;
      mode_s3_q <= '0;
      mode_use_q <= '0;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      upd_sys_q <= '0;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      mode_s1_q <= mode_q;
      mode_s2_q <= mode_s1_q;
      mode_s3_q <= mode_s2_q;
      mode_use_q <= mode_use_d;
      tgl_s1_q <= tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      upd_sys_q <= upd_sys_d;
      pin_s1_q <= pad_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ****************************************************************
  // Pad and core drivers.
  // ****************************************************************
  bstap_pkg::bstap_drive_t bsr_drv, pad_q, pad_d;
  logic [`BSTAP_NRX-1:0] bsr_rx, core_in_q, core_in_d;

  generate
    for (g = 0; g < `BSTAP_NIO; g++) begin : g_io_drv
      assign bsr_rx[g] = upd_sys_q[3*g];
      assign bsr_drv.dat[g] = upd_sys_q[3*g+1];
      assign bsr_drv.oe[g] = upd_sys_q[3*g+2];
    end
    for (g = 0; g < `BSTAP_NOUT; g++) begin : g_out_drv
      assign bsr_drv.dat[`BSTAP_NIO+g] = upd_sys_q[`BSTAP_OUT_CELL+2*g];
      assign bsr_drv.oe[`BSTAP_NIO+g] = upd_sys_q[`BSTAP_OUT_CELL+2*g+1];
    end
    for (g = 0; g < `BSTAP_NIN; g++) begin : g_in_drv
      assign bsr_rx[`BSTAP_NIO+g] = upd_sys_q[`BSTAP_IN_CELL+g];
    end
  endgenerate

  always_comb begin
    pad_d = core_drv;
    core_in_d = pin_s2_q;
    if (mode_use_q.hiz) begin
      pad_d = '0;
    end else if (mode_use_q.pad_from_bsr) begin
      pad_d = bsr_drv;
    end
    if (mode_use_q.core_from_bsr) begin
      core_in_d = bsr_rx;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pad_q <= '0;
      core_in_q <= '0;
    end else begin
      pad_q <= pad_d;
      core_in_q <= core_in_d;
    end
  end

  assign pad_drv = pad_q;
  assign core_in = core_in_q;

endmodule
`default_nettype wire

// ===== core/bstap_map.svh
// Overview of operation
// - The controller is a sixteen-state machine steering every scan mode.
// - Test reset low holds the controller in reset; operation needs it high.
// - Mode select moves states each test clock; five ones return to normal.
// - Input pins get one cell, outputs two, two-way pins three cells.
// - The boundary chain between data in and data out is 484 cells.
// - The instruction register is four bits, shifted in least bit first.
// - External test captures pins, shifts the vector, then updates pins.
// - Internal test captures core outputs and updates the core's inputs.
// - Sample and preload snapshots pins without disturbing normal work.
// - Identity register is 32 bits: version, part, maker, lowest bit one.
// - Entering test-logic-reset loads the identity instruction code.
// - Bypass passes each bit from data in to data out one clock later.
// - Clamp drives pins from held boundary contents with bypass on the path.
// - High-impedance mode turns off every system output while selected.
`ifndef BSTAP_MAP_SVH
`define BSTAP_MAP_SVH

// ****************************************************************
// Sizes of the scan structure.
// ****************************************************************
`define BSTAP_IR_W 4
`define BSTAP_ID_W 32
`define BSTAP_NCELLS 484
`define BSTAP_NIO 160
`define BSTAP_NOUT 1
`define BSTAP_NIN 2
`define BSTAP_NDRV 161
`define BSTAP_NRX 162
`define BSTAP_OUT_CELL 480
`define BSTAP_IN_CELL 482

// ****************************************************************
// Instruction codes and fixed register values.
// ****************************************************************
`define BSTAP_OP_EXTEST 4'h0
`define BSTAP_OP_SAMPLE 4'h1
`define BSTAP_OP_INTEST 4'h2
`define BSTAP_OP_IDCODE 4'h3
`define BSTAP_OP_CLAMP 4'h4
`define BSTAP_OP_HIGHZ 4'h5
`define BSTAP_OP_BYPASS 4'hf
`define BSTAP_IR_CAPT 4'h1
`define BSTAP_ID_LSB 1'h1
`define BSTAP_BYP_CAPT 1'h0

`endif

// ===== core/bstap_pkg.sv
`include "bstap_map.svh"
package bstap_pkg;

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
    ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bstap_state_t;

  typedef struct packed {
    logic [`BSTAP_NDRV-1:0] dat;
    logic [`BSTAP_NDRV-1:0] oe;
  } bstap_drive_t;

  typedef struct packed {
    logic pad_from_bsr;
    logic core_from_bsr;
    logic hiz;
  } bstap_mode_t;

endpackage

// ===== core/bstap_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module bstap_ctrl (
  // Test clock and reset
  input wire logic tck,
  input wire logic trst_n,
  // Mode select
  input wire logic tms,
  // Controller state
  output bstap_pkg::bstap_state_t state
);

  bstap_pkg::bstap_state_t state_q, state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      bstap_pkg::ST_TLR:
        state_d = tms ? bstap_pkg::ST_TLR : bstap_pkg::ST_RTI;
      bstap_pkg::ST_RTI:
        state_d = tms ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_RTI;
      bstap_pkg::ST_SEL_DR:
        state_d = tms ? bstap_pkg::ST_SEL_IR : bstap_pkg::ST_CAP_DR;
      bstap_pkg::ST_CAP_DR:
        state_d = tms ? bstap_pkg::ST_EX1_DR : bstap_pkg::ST_SH_DR;
      bstap_pkg::ST_SH_DR:
        state_d = tms ? bstap_pkg::ST_EX1_DR : bstap_pkg::ST_SH_DR;
      bstap_pkg::ST_EX1_DR:
        state_d = tms ? bstap_pkg::ST_UPD_DR : bstap_pkg::ST_PAU_DR;
      bstap_pkg::ST_PAU_DR:
        state_d = tms ? bstap_pkg::ST_EX2_DR : bstap_pkg::ST_PAU_DR;
      bstap_pkg::ST_EX2_DR:
        state_d = tms ? bstap_pkg::ST_UPD_DR : bstap_pkg::ST_SH_DR;
      bstap_pkg::ST_UPD_DR:
        state_d = tms ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_RTI;
      bstap_pkg::ST_SEL_IR:
        state_d = tms ? bstap_pkg::ST_TLR : bstap_pkg::ST_CAP_IR;
      bstap_pkg::ST_CAP_IR:
        state_d = tms ? bstap_pkg::ST_EX1_IR : bstap_pkg::ST_SH_IR;
      bstap_pkg::ST_SH_IR:
        state_d = tms ? bstap_pkg::ST_EX1_IR : bstap_pkg::ST_SH_IR;
      bstap_pkg::ST_EX1_IR:
        state_d = tms ? bstap_pkg::ST_UPD_IR : bstap_pkg::ST_PAU_IR;
      bstap_pkg::ST_PAU_IR:
        state_d = tms ? bstap_pkg::ST_EX2_IR : bstap_pkg::ST_PAU_IR;
      bstap_pkg::ST_EX2_IR:
        state_d = tms ? bstap_pkg::ST_UPD_IR : bstap_pkg::ST_SH_IR;
      bstap_pkg::ST_UPD_IR:
        state_d = tms ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_RTI;
      default: state_d = bstap_pkg::ST_TLR;
    endcase
  end

  // Sixteen states stepped by the mode select level; reset forces TLR.
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      state_q <= bstap_pkg::ST_TLR;
    end else begin
      state_q <= state_d;
    end
  end

  assign state = state_q;

endmodule
`default_nettype wire

// ===== core/bstap_bsr.sv
`timescale 1ns/1ps
`default_nettype none
`include "bstap_map.svh"
module bstap_bsr (
  // Test clock and reset
  input wire logic tck,
  input wire logic trst_n,
  // Controls
  input wire logic capture,
  input wire logic shift,
  input wire logic update,
  // Serial path
  input wire logic tdi,
  output logic so,
  // Parallel sides
  input wire logic [`BSTAP_NCELLS-1:0] cap_vec,
  output logic [`BSTAP_NCELLS-1:0] upd_vec
);

  logic [`BSTAP_NCELLS-1:0] sr_q, sr_d, upd_q, upd_d;

  always_comb begin
    sr_d = sr_q;
    upd_d = upd_q;
    if (capture) begin
      sr_d = cap_vec;
    end else if (shift) begin
      sr_d = {tdi, sr_q[`BSTAP_NCELLS-1:1]};
    end
    if (update) begin
      upd_d = sr_q;
    end
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      sr_q <= '0;
      upd_q <= '0;
    end else begin
      sr_q <= sr_d;
      upd_q <= upd_d;
    end
  end

  assign so = sr_q[0];
  assign upd_vec = upd_q;

endmodule
`default_nettype wire

// ===== tb/bstap_top_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "bstap_map.svh"
// ******************************
// Port checker of the scan port.
// ******************************
module bstap_top_props (
  // Clocks and resets
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic trst_n,
  // Test access port
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  // Pads and core
  input wire logic [`BSTAP_NRX-1:0] pad_in,
  input wire bstap_pkg::bstap_drive_t pad_drv,
  input wire bstap_pkg::bstap_drive_t core_drv,
  input wire logic [`BSTAP_NRX-1:0] core_in
);
  logic [1:0] hold_q;
  logic [2:0] rcnt_q;
  logic [2:0] tcnt_q;

  // Keeps the serial outputs as they were before each rising test clock.
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      hold_q <= 2'h0;
    end else begin
      hold_q <= {tdo, tdo_oe};
    end
  end

  // Counts cycles since reset release and cycles with test reset held.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_q <= 3'h0;
      tcnt_q <= 3'h0;
    end else begin
      rcnt_q <= (rcnt_q == 3'h7) ? rcnt_q : rcnt_q + 3'h1;
      tcnt_q <= trst_n ? 3'h0 : ((tcnt_q == 3'h7) ? tcnt_q : tcnt_q + 3'h1);
    end
  end

  property p_tdo_hold;
    @(negedge tck) disable iff (!trst_n) {tdo, tdo_oe} == hold_q;
  endproperty
  a_tdo_hold: assert property (p_tdo_hold)
    else $error("serial output moved on a rising test clock");

  property p_idle_zero;
    @(posedge tck) disable iff (!trst_n) !tdo_oe |-> !tdo;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("serial output high while not driven");

  property p_oe_entry;
    @(posedge tck) disable iff (!trst_n)
      $rose(tdo_oe) |-> !$past(tms) && !$past(tms, 2);
  endproperty
  a_oe_entry: assert property (p_oe_entry)
    else $error("shift entered without two low mode selects");

  property p_oe_exit;
    @(posedge tck) disable iff (!trst_n) tdo_oe && tms |=> !tdo_oe;
  endproperty
  a_oe_exit: assert property (p_oe_exit)
    else $error("shift not left on high mode select");

  property p_oe_stay;
    @(posedge tck) disable iff (!trst_n) tdo_oe && !tms |=> tdo_oe;
  endproperty
  a_oe_stay: assert property (p_oe_stay)
    else $error("shift left on low mode select");

  property p_tms_reset;
    @(posedge tck) disable iff (!trst_n) tms [*5] |=> !tdo_oe;
  endproperty
  a_tms_reset: assert property (p_tms_reset)
    else $error("five high mode selects left output driven");

  property p_trst_quiet;
    @(posedge clk_sys) disable iff (!rst_n) !trst_n |-> !tdo_oe && !tdo;
  endproperty
  a_trst_quiet: assert property (p_trst_quiet)
    else $error("serial output active in test reset");

  property p_norm_core;
    @(posedge clk_sys) disable iff (!rst_n)
      rcnt_q == 3'h7 && tcnt_q == 3'h7 |-> core_in == $past(pad_in, 3);
  endproperty
  a_norm_core: assert property (p_norm_core)
    else $error("core inputs do not follow pads");

  property p_norm_pad;
    @(posedge clk_sys) disable iff (!rst_n)
      rcnt_q == 3'h7 && tcnt_q == 3'h7 |-> pad_drv == $past(core_drv);
  endproperty
  a_norm_pad: assert property (p_norm_pad)
    else $error("pads do not follow the core");
endmodule

bind bstap_top bstap_top_props u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .trst_n(trst_n),
  .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in),
  .pad_drv(pad_drv), .core_drv(core_drv), .core_in(core_in)
);
`default_nettype wire

// ===== tb/bstap_tester.sv
`timescale 1ns/1ps
`default_nettype none
// ******************************
// Scan tester at the test port.
// ******************************
module bstap_tester (
  // Test port toward the device
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One test clock; between frames the clock stands low.
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #80;
    o = tdo;
    tck = 1'b1;
    #80;
    tck = 1'b0;
  endtask

  task automatic go_reset();
    logic o;
    #3;
    repeat (5) tick(1'b1, 1'b1, o);
  endtask

  task automatic shift_dr(input int n, input logic [491:0] di,
                          output logic [491:0] dq);
    logic o;
    dq = '0;
    #3;
    tick(1'b0, 1'b1, o);
    tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
    tick(1'b0, 1'b1, o);
    for (int k = 0; k < n; k++) begin
      tick(k == n - 1, di[k], o);
      dq[k] = o;
    end
    tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
    tick(1'b0, 1'b1, o);
  endtask

  // The code goes in least significant bit first.
  task automatic shift_ir(input logic [3:0] c, output logic [3:0] q);
    logic o;
    #3;
    tick(1'b0, 1'b1, o);
    tick(1'b1, 1'b1, o);
    tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
    tick(1'b0, 1'b1, o);
    for (int k = 0; k < 4; k++) begin
      tick(k == 3, c[k], o);
      q[k] = o;
    end
    // Passes through the pause state on the way to the update.
    tick(1'b0, 1'b1, o);
    tick(1'b1, 1'b1, o);
    tick(1'b1, 1'b1, o);
    repeat (3) tick(1'b0, 1'b1, o);
  endtask
endmodule
`default_nettype wire

// ===== tb/boundary_scan_tap_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bstap_map.svh"
// ******************************
// Self-checking bench.
// ******************************
module boundary_scan_tap_tb_top;
  // Identity fields; the values are arbitrary.
  localparam logic [3:0] ID_V = 4'h6;
  localparam logic [15:0] ID_P = 16'h5a3c;
  localparam logic [10:0] ID_M = 11'h155;
  logic clk_sys, rst_n, trst_n, tck, tms, tdi, tdo, tdo_oe;
  logic [`BSTAP_NRX-1:0] pad_in;
  logic [`BSTAP_NRX-1:0] core_in;
  bstap_pkg::bstap_drive_t pad_drv;
  bstap_pkg::bstap_drive_t core_drv;
  logic [491:0] din;
  logic [491:0] dout;
  logic [483:0] vec;
  logic [3:0] irq;
  int error_cnt;
  int tests_run;

  bstap_top #(.ID_VERSION(ID_V), .ID_PART(ID_P), .ID_MAKER(ID_M)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .trst_n(trst_n),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in),
    .pad_drv(pad_drv), .core_drv(core_drv), .core_in(core_in)
  );
  bstap_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [511:0] rnd();
    logic [511:0] r;
    for (int k = 0; k < 16; k++) r[32*k +: 32] = $urandom;
    return r;
  endfunction

  function automatic logic [483:0] cap_of(input logic [161:0] p,
                                          input bstap_pkg::bstap_drive_t c);
    logic [483:0] r;
    for (int i = 0; i < 160; i++) begin
      r[3*i] = p[i];
      r[3*i+1] = c.dat[i];
      r[3*i+2] = c.oe[i];
    end
    r[483:480] = {p[161:160], c.oe[160], c.dat[160]};
    return r;
  endfunction

  function automatic bstap_pkg::bstap_drive_t drv_of(input logic [483:0] c);
    bstap_pkg::bstap_drive_t d;
    for (int i = 0; i < 160; i++) begin
      d.dat[i] = c[3*i+1];
      d.oe[i] = c[3*i+2];
    end
    d.dat[160] = c[480];
    d.oe[160] = c[481];
    return d;
  endfunction

  function automatic logic [161:0] in_of(input logic [483:0] c);
    logic [161:0] r;
    for (int i = 0; i < 160; i++) r[i] = c[3*i];
    r[161:160] = c[483:482];
    return r;
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [511:0] seen, input logic [511:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Waits, bounded, for pads (sel low) or core inputs to reach a value.
  task automatic settle(input logic sel, input logic [511:0] e);
    int n;
    n = 0;
    while ((sel ? 512'(core_in) : 512'(pad_drv)) !== e && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    check(sel ? 512'(core_in) : 512'(pad_drv), e);
    if ((sel ? 512'(core_in) : 512'(pad_drv)) !== e) begin
      report_and_stop();
    end
  endtask

  task automatic new_inputs();
    logic [511:0] r;
    r = rnd();
    @(posedge clk_sys);
    pad_in <= r[161:0];
    core_drv <= bstap_pkg::bstap_drive_t'(r[483:162]);
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic read_id();
    din = 492'(rnd());
    tester.shift_dr(32, din, dout);
    check(dout[31:0], {ID_V, ID_P, ID_M, 1'b1});
    check(tdo_oe, 1'b0);
  endtask

  task automatic ir_bypass(input logic [3:0] code);
    tester.shift_ir(code, irq);
    check(irq, `BSTAP_IR_CAPT);
    din = 492'(rnd());
    tester.shift_dr(16, din, dout);
    check(dout[15:0], {din[14:0], `BSTAP_BYP_CAPT});
  endtask

  // Shifts a full boundary vector plus eight bits that come back out.
  task automatic scan_bsr();
    din = 492'(rnd());
    tester.shift_dr(492, din, dout);
    check(dout[483:0], cap_of(pad_in, core_drv));
    check(dout[491:484], din[7:0]);
    vec = din[491:8];
  endtask

  initial begin
    #950_000;
    error_cnt++;
    $display("BAD t=%0t run did not finish", $time);
    report_and_stop();
  end

  initial begin
    error_cnt = 0;
    tests_run = 0;
    rst_n = 1'b0;
    trst_n = 1'b0;
    pad_in = '0;
    core_drv = '0;
    void'($urandom(32'hf484));
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    new_inputs();
    check(pad_drv, core_drv);
    trst_n <= 1'b1;
    read_id();
    $display("test identity done");
    ir_bypass(`BSTAP_OP_BYPASS);
    // Codes six to fourteen are unassigned and must act as bypass.
    ir_bypass(4'h6 + 4'($urandom_range(8)));
    $display("test bypass done");
    new_inputs();
    tester.shift_ir(`BSTAP_OP_SAMPLE, irq);
    scan_bsr();
    check(pad_drv, core_drv);
    $display("test sample done");
    tester.shift_ir(`BSTAP_OP_EXTEST, irq);
    settle(1'b0, drv_of(vec));
    scan_bsr();
    settle(1'b0, drv_of(vec));
    $display("test extest done");
    new_inputs();
    ir_bypass(`BSTAP_OP_CLAMP);
    check(pad_drv, drv_of(vec));
    $display("test clamp done");
    tester.shift_ir(`BSTAP_OP_INTEST, irq);
    settle(1'b1, in_of(vec));
    scan_bsr();
    settle(1'b1, in_of(vec));
    $display("test intest done");
    tester.shift_ir(`BSTAP_OP_HIGHZ, irq);
    settle(1'b0, '0);
    tester.go_reset();
    settle(1'b0, core_drv);
    settle(1'b1, pad_in);
    $display("test highz and return done");
    tester.shift_ir(`BSTAP_OP_EXTEST, irq);
    @(posedge clk_sys);
    trst_n <= 1'b0;
    settle(1'b0, core_drv);
    check(tdo_oe, 1'b0);
    @(posedge clk_sys);
    trst_n <= 1'b1;
    read_id();
    $display("test second reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
